// [tdpc_pkg.sv]
// shared constants and types for the dual pwm / capture timer
package tdpc_pkg;
   // ---------------------------------------------------------------
   // register word indexes, byte address is index times four
   // ---------------------------------------------------------------
   localparam logic [3:0] IDX_CNT_HI = 4'h0;
   localparam logic [3:0] IDX_CNT_LO = 4'h1;
   localparam logic [3:0] IDX_RLD_HI = 4'h2;
   localparam logic [3:0] IDX_RLD_LO = 4'h3;
   localparam logic [3:0] IDX_CMP_HI = 4'h4;
   localparam logic [3:0] IDX_CMP_LO = 4'h5;
   localparam logic [3:0] IDX_CTL0 = 4'h6;
   localparam logic [3:0] IDX_CTL1 = 4'h7;
   localparam logic [3:0] IDX_DEAD = 4'h8;
   localparam logic [3:0] IDX_IRQ_PEND = 4'h9;
   localparam logic [3:0] IDX_IRQ_MASK = 4'ha;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTL1_EN = 7;
   localparam int CTL1_POL = 6;
   localparam int CTL1_PRE_LSB = 3;
   localparam int CTL1_MODE_LSB = 0;
   localparam int CTL0_MODE_HI = 7;
   localparam int CTL0_GIE = 0;
   localparam int FIRST_TIMER_BIT = 5;
   localparam int SECOND_TIMER_BIT = 6;
   // ---------------------------------------------------------------
   // reset values and modes
   // ---------------------------------------------------------------
   localparam logic [15:0] CNT_RESTART = 16'h0001;
   localparam logic [15:0] CNT_RESET = 16'h0001;
   localparam logic [15:0] RLD_RESET = 16'hffff;
   localparam logic [7:0] IRQ_VALID = 8'h60;
   localparam logic [3:0] MODE_CONT = 4'h1;
   localparam logic [3:0] MODE_PWM = 4'h3;
   localparam logic [3:0] MODE_CAPTURE = 4'h4;
   localparam logic [3:0] MODE_CAPCMP = 4'h7;
   localparam logic [3:0] MODE_DUAL = 4'h8;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT_EDGE = 3'b010,
      ST_RUN = 3'b100
   } tdpc_phase_type;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] rld;
      logic [7:0] rld_tmp;
      logic [15:0] cmp;
      logic [7:0] hold;
      logic [7:0] ctl0;
      logic [7:0] ctl1;
      logic [7:0] dead;
      logic [7:0] pend;
      logic [7:0] mask;
      tdpc_phase_type phase;
      logic out_lvl;
      logic [7:0] dead_cnt;
      logic tout;
      logic toutn;
      logic toutn_oe;
      logic irq;
      logic tin_s1;
      logic tin_s2;
      logic tin_prev;
      logic a_wr;
      logic a_rd;
      logic [3:0] a_idx;
      logic ready;
      logic [31:0] rdata;
   } tdpc_state_type;
endpackage

// [tdpc_prescale.sv]
// prescaler that turns the system clock into a count enable pulse
`timescale 1ns/1ps
module tdpc_prescale
   import tdpc_pkg::*;
#(
   parameter int WIDTH = 7
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [2:0] sel,
   output logic tick
);
   logic [WIDTH-1:0] div_q;
   logic [WIDTH-1:0] mask;

   // divide by two to the power of sel, so the pwm period scales by it
   assign mask = WIDTH'((1 << sel) - 1);
   assign tick = run && ((div_q & mask) == mask);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= '0;
      end else if (!run) begin
         // restart so the first pass is a full prescale period
         div_q <= '0;
      end else begin
         div_q <= div_q + WIDTH'(1);
      end
   end
endmodule

// [tdpc_timer.sv]
// 16-bit timer with dual pwm, deadband and capture, on an ahb-lite slave
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - prescale, start level and transition polarity are programmable
// - pwm passes after the first restart counting from 0001h
// - dual mode turns the shared input pin into complement output
// - period is reload times prescale over clock frequency
// - first pass runs from the loaded start value up to reload
// - interrupt mask and enable are optional, set before enabling
// - capture/compare starts on first input edge, that edge no interrupt
// - elapsed time is capture minus start, times prescale
// - a timer event sets its pending bit, bit 6 or bit 5
// - global enable forwards pending requests, otherwise software polls
// - compare match flips the pwm output, polarity sets levels
// - capture modes store the count in the compare bytes
// - dual mode ignores the timer input
module tdpc_timer
   import tdpc_pkg::*;
#(
   parameter int IRQ_BIT = FIRST_TIMER_BIT
) (
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   input wire logic TIN,
   output logic TOUT,
   output logic TOUTN,
   output logic TOUTN_OE,
   output logic IRQ
);
   tdpc_state_type q;
   tdpc_state_type d;
   logic tick;
   logic [3:0] mode;
   logic en;
   logic pol;
   logic is_dual;
   logic is_pwm;
   logic is_cap;
   logic is_capcmp;
   logic edge_now;
   logic event_now;
   logic [7:0] wb;

   assign mode = {q.ctl0[CTL0_MODE_HI], q.ctl1[CTL1_MODE_LSB +: 3]};
   assign en = q.ctl1[CTL1_EN];
   assign pol = q.ctl1[CTL1_POL];
   assign is_dual = (mode == MODE_DUAL);
   assign is_pwm = is_dual || (mode == MODE_PWM);
   assign is_cap = (mode == MODE_CAPTURE);
   assign is_capcmp = (mode == MODE_CAPCMP);
   assign wb = HWDATA[7:0];
   // polarity picks the qualifying edge; dual mode has no input at all
   assign edge_now = !is_dual && (q.tin_s2 != q.tin_prev) && (q.tin_s2 != pol);

   tdpc_prescale #(
      .WIDTH(7)
   ) u_pre (
      .clk(REF_CLK),
      .rst_n(NRST),
      .run(en && (q.phase == ST_RUN || (q.phase == ST_WAIT_EDGE && edge_now))),
      .sel(q.ctl1[CTL1_PRE_LSB +: 3]),
      .tick(tick)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      event_now = 1'b0;
      d.tin_s1 = TIN;
      d.tin_s2 = q.tin_s1;
      d.tin_prev = q.tin_s2;
      // counting and pwm
      case (q.phase)
         ST_IDLE: begin
         end
         ST_WAIT_EDGE: begin
            if (edge_now) begin
               d.phase = ST_RUN;
               // prescaler starts on this edge, so start-to-capture spans match
               if (tick) begin
                  d.cnt = q.cnt + 16'h0001;
               end
            end
         end
         ST_RUN: begin
            if ((is_cap || is_capcmp) && edge_now) begin
               d.cmp = q.cnt;
               event_now = 1'b1;
               if (is_capcmp) begin
                  d.cnt = CNT_RESTART;
               end
            end else if (tick) begin
               if (q.cnt == q.rld) begin
                  // reload restarts at 0001h whatever the start value was
                  d.cnt = CNT_RESTART;
                  event_now = 1'b1;
                  d.out_lvl = is_pwm ? pol : !q.out_lvl;
               end else begin
                  d.cnt = q.cnt + 16'h0001;
                  if (is_pwm && q.cnt == q.cmp) begin
                     d.out_lvl = !pol;
                  end
               end
            end
         end
         default: begin
            d.phase = ST_IDLE;
         end
      endcase
      // deadband counts system clocks, not prescaled ticks
      if (d.out_lvl != q.out_lvl) begin
         d.dead_cnt = q.dead;
      end else if (q.dead_cnt != 8'h00) begin
         d.dead_cnt = q.dead_cnt - 8'h01;
      end
      // ahb data phase: writes land here, before reads and flags
      if (q.a_wr) begin
         case (q.a_idx)
            IDX_CNT_HI: d.cnt[15:8] = wb;
            IDX_CNT_LO: d.cnt[7:0] = wb;
            IDX_RLD_HI: d.rld_tmp = wb;
            IDX_RLD_LO: d.rld = {q.rld_tmp, wb};
            IDX_CMP_HI: d.cmp[15:8] = wb;
            IDX_CMP_LO: d.cmp[7:0] = wb;
            IDX_CTL0: d.ctl0 = wb;
            IDX_DEAD: d.dead = wb;
            IDX_IRQ_PEND: d.pend = wb & IRQ_VALID;
            IDX_IRQ_MASK: d.mask = wb & IRQ_VALID;
            IDX_CTL1: begin
               d.ctl1 = wb;
               if (!wb[CTL1_EN]) begin
                  d.phase = ST_IDLE;
               end else if (!en) begin
                  // enabling is the step that starts the timer
                  d.phase = (wb[2:0] == MODE_CAPCMP[2:0] && !q.ctl0[CTL0_MODE_HI]) ?
                     ST_WAIT_EDGE : ST_RUN;
                  d.out_lvl = wb[CTL1_POL];
                  // a level change at enable is a transition too, so it gets the gap
                  d.dead_cnt = (wb[CTL1_POL] != q.out_lvl) ? q.dead : 8'h00;
               end
            end
            default: begin
            end
         endcase
      end
      d.ready = 1'b1;
      if (q.a_rd) begin
         d.rdata = 32'h0000_0000;
         case (q.a_idx)
            IDX_CNT_HI: begin
               d.rdata[7:0] = q.cnt[15:8];
               d.hold = q.cnt[7:0];
            end
            IDX_CNT_LO: d.rdata[7:0] = en ? q.hold : q.cnt[7:0];
            IDX_RLD_HI: d.rdata[7:0] = q.rld[15:8];
            IDX_RLD_LO: d.rdata[7:0] = q.rld[7:0];
            IDX_CMP_HI: d.rdata[7:0] = q.cmp[15:8];
            IDX_CMP_LO: d.rdata[7:0] = q.cmp[7:0];
            IDX_CTL0: d.rdata[7:0] = q.ctl0;
            IDX_CTL1: d.rdata[7:0] = q.ctl1;
            IDX_DEAD: d.rdata[7:0] = q.dead;
            IDX_IRQ_PEND: begin
               d.rdata[7:0] = q.pend;
               d.pend = 8'h00; // read clears, new events below still win
            end
            IDX_IRQ_MASK: d.rdata[7:0] = q.mask;
            default: begin
            end
         endcase
      end
      if (event_now) begin
         d.pend[IRQ_BIT] = 1'b1;
      end
      // address phase: reads take one wait state so hrdata is a flop
      d.a_wr = 1'b0;
      d.a_rd = 1'b0;
      if (HSEL && HTRANS[1] && HREADY && q.ready) begin
         d.a_idx = HADDR[5:2];
         d.a_wr = HWRITE;
         d.a_rd = !HWRITE;
         d.ready = HWRITE;
      end
      // pins
      d.toutn_oe = (d.ctl0[CTL0_MODE_HI] && d.ctl1[2:0] == MODE_DUAL[2:0]);
      if (d.toutn_oe && d.dead_cnt != 8'h00) begin
         d.tout = 1'b0;
         d.toutn = 1'b0;
      end else begin
         d.tout = d.out_lvl;
         d.toutn = d.toutn_oe && !d.out_lvl;
      end
      d.irq = d.ctl0[CTL0_GIE] && |(d.pend & d.mask);
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         q <= '0;
         q.cnt <= CNT_RESET;
         q.rld <= RLD_RESET;
         q.phase <= ST_IDLE;
         q.ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign HREADYOUT = q.ready;
   assign HRDATA = q.rdata;
   assign HRESP = 1'b0;
   assign TOUT = q.tout;
   assign TOUTN = q.toutn;
   assign TOUTN_OE = q.toutn_oe;
   assign IRQ = q.irq;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_restart;
      @(posedge REF_CLK) disable iff (!NRST)
         (q.phase == ST_RUN && is_pwm && tick && q.cnt == q.rld && !q.a_wr)
         |=> q.cnt == 16'h0001;
   endproperty
   a_restart: assert property (p_restart) else $error("count not restarted at 1");

   property p_pin_dir;
      @(posedge REF_CLK) disable iff (!NRST)
         !q.a_wr |=> TOUTN_OE == $past(is_dual);
   endproperty
   a_pin_dir: assert property (p_pin_dir) else $error("shared pin direction wrong");

   property p_no_overlap;
      @(posedge REF_CLK) disable iff (!NRST)
         !(TOUT && TOUTN);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("both outputs high");

   property p_deadband;
      @(posedge REF_CLK) disable iff (!NRST)
         (is_dual && $changed(q.out_lvl) && q.dead != 8'h00) |-> (!TOUT && !TOUTN);
   endproperty
   a_deadband: assert property (p_deadband) else $error("no deadband gap");

   property p_first_edge;
      @(posedge REF_CLK) disable iff (!NRST)
         (q.phase == ST_WAIT_EDGE && edge_now && !q.a_wr && !q.a_rd)
         |=> q.phase == ST_RUN && q.pend[IRQ_BIT] == $past(q.pend[IRQ_BIT]);
   endproperty
   a_first_edge: assert property (p_first_edge) else $error("first edge mishandled");

   property p_pend_set;
      @(posedge REF_CLK) disable iff (!NRST)
         event_now |=> q.pend[IRQ_BIT] && (IRQ || !(q.ctl0[CTL0_GIE] && q.mask[IRQ_BIT]));
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("pending bit not set");

   property p_irq_out;
      @(posedge REF_CLK) disable iff (!NRST)
         IRQ == (q.ctl0[CTL0_GIE] && |(q.pend & q.mask));
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("irq output wrong");

   property p_capture;
      @(posedge REF_CLK) disable iff (!NRST)
         (q.phase == ST_RUN && (is_cap || is_capcmp) && edge_now && !q.a_wr)
         |=> q.cmp == $past(q.cnt);
   endproperty
   a_capture: assert property (p_capture) else $error("capture value lost");

   property p_prescale;
      @(posedge REF_CLK) disable iff (!NRST)
         (tick && q.ctl1[CTL1_PRE_LSB +: 3] != 3'h0 && !q.a_wr) |=> !tick;
   endproperty
   a_prescale: assert property (p_prescale) else $error("prescale tick too fast");

   property p_count_up;
      @(posedge REF_CLK) disable iff (!NRST)
         (q.phase == ST_RUN && is_pwm && tick && q.cnt != q.rld && !q.a_wr)
         |=> q.cnt == $past(q.cnt) + 16'h0001;
   endproperty
   a_count_up: assert property (p_count_up) else $error("count did not step up");

   property p_match;
      @(posedge REF_CLK) disable iff (!NRST)
         (q.phase == ST_RUN && is_pwm && tick && q.cnt == q.cmp && q.cnt != q.rld && !q.a_wr)
         |=> q.out_lvl == !pol;
   endproperty
   a_match: assert property (p_match) else $error("compare match did not flip");

   property p_capcmp_restart;
      @(posedge REF_CLK) disable iff (!NRST)
         (q.phase == ST_RUN && is_capcmp && edge_now && !q.a_wr)
         |=> q.cnt == CNT_RESTART;
   endproperty
   a_capcmp_restart: assert property (p_capcmp_restart) else $error("no restart");

   property p_dual_no_input;
      @(posedge REF_CLK) disable iff (!NRST)
         (is_dual && !q.a_wr) |=> q.cmp == $past(q.cmp);
   endproperty
   a_dual_no_input: assert property (p_dual_no_input) else $error("dual mode captured");
endmodule

// [tdpc_pin_model.sv]
// far-side pin model: drives the shared timer input pin with a chosen lag
`timescale 1ns/1ps
module tdpc_pin_model (
   input wire logic clk,
   input wire logic lvl,
   input wire logic [2:0] lag,
   input wire logic toutn,
   input wire logic toutn_oe,
   output logic pin
);
   // ------------------------------------------------------------
   // delayed drive; lag 0 answers promptly, larger lags slowly
   // ------------------------------------------------------------
   logic [7:0] sh_q = 8'h00;
   always @(posedge clk) begin
      sh_q <= {sh_q[6:0], lvl};
   end
   // backs off while the timer owns the pin, so no contention
   assign pin = toutn_oe ? toutn : sh_q[lag];
endmodule

// [timer_dual_pwm_capture_tb.sv]
// self-checking bench for the dual pwm / capture timer
`timescale 1ns/1ps
module timer_dual_pwm_capture_tb;
   import tdpc_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic lvl = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, tout, toutn, toutn_oe, irq, pin;
   logic [2:0] lag = 3'h0;
   logic [31:0] seed = 32'h21be;
   logic [31:0] exp_q[$];
   logic rd_pend = 1'b0;
   int error_cnt = 0;
   int compares = 0;
   int c;
   tdpc_timer tdpc_timer_inst (.REF_CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
      .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
      .TIN(pin), .TOUT(tout), .TOUTN(toutn), .TOUTN_OE(toutn_oe), .IRQ(irq));
   tdpc_pin_model tdpc_pin_model_inst (.clk(clk), .lvl(lvl), .lag(lag), .toutn(toutn),
      .toutn_oe(toutn_oe), .pin(pin));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // sampled at the falling edge, clear of the registered outputs' updates
   task automatic wait_rdy;
      do @(negedge clk); while (hreadyout !== 1'b1);
      @(posedge clk);
   endtask
   task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {26'h0, idx, 2'b00};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
   endtask
   task automatic rd(input logic [3:0] idx, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, idx, 32'h0);
   endtask
   task automatic to_level(input logic v, inout int n);
      do begin
         @(negedge clk);
         n++;
      end while (tout !== v);
   endtask
   task automatic report_and_stop;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // clock, watchdog and read-data monitor
   // ------------------------------------------------------------
   initial forever #25 clk = ~clk;
   initial begin
      #(50 * 20000);
      error_cnt++;
      report_and_stop();
   end
   always @(negedge clk) begin
      if (rd_pend && hreadyout) begin
         rd_pend = 1'b0;
         chk("hrdata", exp_q.pop_front(), hrdata);
         chk("hresp", 32'h0, {31'h0, hresp});
      end else if (hsel && htrans[1] && !hwrite && hreadyout) begin
         rd_pend = 1'b1;
      end
      if (tout && toutn) chk("outputs overlap", 32'h0, 32'h1);
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      rd(IDX_CNT_LO, 32'h01);
      rd(IDX_RLD_HI, 32'hff);
      rd(IDX_IRQ_PEND, 32'h0);
      rd(4'hb, 32'h0);
      seed = lfsr(seed);
      bus(1'b1, IDX_CMP_HI, {24'h0, seed[15:8]});
      bus(1'b1, IDX_CMP_LO, {24'h0, seed[7:0]});
      rd(IDX_CMP_HI, {24'h0, seed[15:8]});
      rd(IDX_CMP_LO, {24'h0, seed[7:0]});
      // pwm pol 0, pwm pol 1, dual pol 0; reload 8, compare 4, prescale 2
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, IDX_CTL1, 32'h0);
         bus(1'b1, IDX_CTL0, {24'h0, k[1], 7'h0});
         bus(1'b1, IDX_CNT_HI, 32'h0);
         bus(1'b1, IDX_CNT_LO, 32'h1);
         bus(1'b1, IDX_CMP_HI, 32'h0);
         bus(1'b1, IDX_CMP_LO, 32'h4);
         bus(1'b1, IDX_DEAD, 32'h3);
         bus(1'b1, IDX_RLD_HI, 32'h0);
         bus(1'b1, IDX_RLD_LO, 32'h8);
         bus(1'b1, IDX_CTL1, {24'h0, 1'b1, k[0], 3'h1, (k[1] ? 3'h0 : 3'h3)});
         repeat (2) @(negedge clk);
         chk("start level", {31'h0, k[0]}, {31'h0, tout});
         chk("pin owner", {31'h0, k[1]}, {31'h0, toutn_oe});
         c = 0;
         to_level(1'b0, c);
         to_level(1'b1, c);
         c = 0;
         to_level(1'b0, c);
         to_level(1'b1, c);
         chk("period", 32'd16, c);
         if (k == 2) begin
            do @(negedge clk); while (toutn !== 1'b1);
            do @(negedge clk); while (toutn !== 1'b0);
            c = 0;
            to_level(1'b1, c);
            chk("deadband", 32'd3, c);
         end
         chk("irq masked", 32'h0, {31'h0, irq});
      end
      // capture/compare: first edge only arms, second edge captures
      bus(1'b1, IDX_CTL1, 32'h0);
      rd(IDX_IRQ_PEND, 32'h20);
      bus(1'b1, IDX_CTL0, 32'h01);
      bus(1'b1, IDX_IRQ_MASK, 32'h20);
      bus(1'b1, IDX_RLD_HI, 32'hff);
      bus(1'b1, IDX_RLD_LO, 32'hff);
      bus(1'b1, IDX_CNT_HI, 32'h0);
      bus(1'b1, IDX_CNT_LO, 32'h1);
      bus(1'b1, IDX_CTL1, 32'h87);
      lag <= 3'h5;
      repeat (10) @(posedge clk);
      lvl <= 1'b1;
      repeat (20) @(posedge clk);
      @(negedge clk);
      chk("irq first edge", 32'h0, {31'h0, irq});
      @(posedge clk);
      lvl <= 1'b0;
      repeat (29) @(posedge clk);
      lvl <= 1'b1;
      repeat (20) @(negedge clk);
      chk("irq capture", 32'h1, {31'h0, irq});
      rd(IDX_CMP_LO, 32'h33);
      rd(IDX_IRQ_PEND, 32'h20);
      rd(IDX_IRQ_PEND, 32'h0);
      repeat (3) @(negedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      // plain capture: count runs from enable, input lag stays at 5
      @(posedge clk);
      lvl <= 1'b0;
      bus(1'b1, IDX_CTL1, 32'h0);
      bus(1'b1, IDX_CNT_HI, 32'h0);
      bus(1'b1, IDX_CNT_LO, 32'h1);
      bus(1'b1, IDX_CTL1, 32'h84);
      repeat (10) @(posedge clk);
      lvl <= 1'b1;
      repeat (20) @(negedge clk);
      chk("irq plain capture", 32'h1, {31'h0, irq});
      rd(IDX_CMP_LO, 32'h13);
      rd(IDX_IRQ_PEND, 32'h20);
      report_and_stop();
   end
endmodule
